// >>> hw/gptc_consts.svh
// Register offsets, field positions and reset values of the general-purpose timer
`ifndef GPTC_CONSTS_SVH
`define GPTC_CONSTS_SVH

`define GPTC_ADDR_RELOAD 32'hffff0380
`define GPTC_ADDR_COUNT 32'hffff0384
`define GPTC_ADDR_CTRL 32'hffff0388
`define GPTC_ADDR_ACK 32'hffff038c
`define GPTC_ADDR_CAPTURE 32'hffff0390
`define GPTC_ADDR_STATUS 32'hffff0394
`define GPTC_ADDR_MASK 32'hffff0398

`define GPTC_RELOAD_RESET 16'h0000
`define GPTC_COUNT_RESET 16'hffff
`define GPTC_CTRL_RESET 32'h00000000
`define GPTC_CAPTURE_RESET 16'h0000
`define GPTC_COUNT_MAX 16'hffff
`define GPTC_COUNT_MIN 16'h0000

`define GPTC_CTRL_WMASK 32'h0003f7cf
`define GPTC_CAPEN_BIT 17
`define GPTC_CAPSEL_HI 16
`define GPTC_CAPSEL_LO 12
`define GPTC_CLKSEL_HI 10
`define GPTC_CLKSEL_LO 9
`define GPTC_DIR_BIT 8
`define GPTC_EN_BIT 7
`define GPTC_MOD_BIT 6
`define GPTC_SCALE_HI 3
`define GPTC_SCALE_LO 0

`define GPTC_SRC_COUNT 18
`define GPTC_ST_TIMEOUT 0
`define GPTC_ST_CAPTURE 1

`endif

// >>> hw/gptc_pkg.sv
// Types of the general-purpose timer
package gptc_pkg;

  typedef enum logic [1:0] {
    GPTC_CLK_OSC32K,
    GPTC_CLK_CORE_DIV,
    GPTC_CLK_CORE,
    GPTC_CLK_RESERVED
  } gptc_clksel_t;

  typedef struct packed {
    logic [15:0] reloadVal;
    logic [15:0] liveCount;
    logic [31:0] control;
    logic [15:0] captured;
    logic [1:0] status;
    logic [1:0] mask;
    logic [14:0] preCnt;
    logic [6:0] cdCnt;
    logic oscSync1;
    logic oscSync2;
    logic oscPrev;
    logic srcPrev;
    logic ack;
    logic [31:0] readData;
  } gptc_state_t;

endpackage : gptc_pkg

// >>> hw/gptc_timer.sv
// General-purpose 16-bit timer with prescaler, reload and event capture
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/1ns
`include "gptc_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - 16-bit counter counts up or down, fed through a programmable prescaler.
// - Reload, live count and capture are 16-bit unsigned; count and capture read-only.
// - On selected source assertion, copy count to capture; counter keeps running.
// - Any write to acknowledge register clears pending timer interrupt; nothing stored.
// - Software-written 16-bit reload value is what the counter loads.
// - Count register reads present value; reads all ones after reset.
// - Control bit 17 enables capture; when clear no capture occurs.
// - Control bits 16:12 pick which source 0 to 17 triggers capture.
// - Bits 10:9 pick clock: oscillator, divided core, undivided core, reserved.
// - Control bit 8 set counts up, clear counts down; down after reset.
// - Control bit 7 enables the counter; disabled after reset.
// - Control bit 6 set selects periodic, clear free-running; free-running after reset.
// - Bits 3:0 set prescale: divide by 1, 16, 256 or 32768.
// - Control register resets to zero; bits 31:18, 11 and 5:4 reserved.
module gptc_timer
  import gptc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [31:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic osc32kIn,
  input wire logic coreTickIn,
  input wire logic [2:0] coreDividerSetting,
  input wire logic [`GPTC_SRC_COUNT-1:0] irqSources,
  output logic timerIrq
);

  gptc_state_t stateReg;
  gptc_state_t stateNext;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte-lane write mask from the byte enables
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : laneMask

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic busReq;
    logic wrEn;
    logic [31:0] wMask;
    logic [31:0] rdMux;
    logic [6:0] cdMask;
    logic cdTick;
    logic oscTick;
    logic srcTick;
    logic [14:0] preMask;
    logic preTick;
    logic countUp;
    logic atTerminal;
    logic [4:0] capSel;
    logic srcLevel;
    logic capEvent;
    logic toEvent;
    gptc_clksel_t clkSel;
    // Decode hits, write strobes and merged write values
    logic rdStrobe;
    logic hitReload;
    logic hitCount;
    logic hitCtrl;
    logic hitAck;
    logic hitCapture;
    logic hitStatus;
    logic hitMask;
    logic wrReload;
    logic wrCtrl;
    logic wrAck;
    logic wrStatus;
    logic wrMask;
    logic atMax;
    logic atMin;
    logic [15:0] cntStep;
    logic [15:0] cntWrap;
    logic [15:0] reloadMerged;
    logic [31:0] ctrlMerged;
    logic [1:0] maskMerged;
    logic [1:0] stSet;
    logic [1:0] stClr;
    logic srcRise;
    logic capArm;
    logic preRun;
    logic preHit;

    stateNext = stateReg;
    busReq = avsRead | avsWrite;
    wrEn = avsWrite & stateReg.ack;
    wMask = laneMask(avsByteEnable);
    rdMux = 32'h00000000;
    toEvent = 1'b0;
    capEvent = 1'b0;
    // Every local starts from a safe value so no path leaves a latch
    cdMask = 7'h00;
    cdTick = 1'b0;
    oscTick = 1'b0;
    srcTick = 1'b0;
    preMask = 15'h0000;
    preTick = 1'b0;
    countUp = 1'b0;
    atTerminal = 1'b0;
    capSel = 5'h00;
    srcLevel = 1'b0;
    clkSel = GPTC_CLK_OSC32K;
    rdStrobe = 1'b0;
    hitReload = 1'b0;
    hitCount = 1'b0;
    hitCtrl = 1'b0;
    hitAck = 1'b0;
    hitCapture = 1'b0;
    hitStatus = 1'b0;
    hitMask = 1'b0;
    wrReload = 1'b0;
    wrCtrl = 1'b0;
    wrAck = 1'b0;
    wrStatus = 1'b0;
    wrMask = 1'b0;
    atMax = 1'b0;
    atMin = 1'b0;
    cntStep = 16'h0000;
    cntWrap = 16'h0000;
    reloadMerged = stateReg.reloadVal;
    ctrlMerged = stateReg.control;
    maskMerged = stateReg.mask;
    stSet = 2'h0;
    stClr = 2'h0;
    srcRise = 1'b0;
    capArm = 1'b0;
    preRun = 1'b0;
    preHit = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, one hit per register
    if (avsAddress == `GPTC_ADDR_RELOAD) begin
      hitReload = 1'b1;
    end else if (avsAddress == `GPTC_ADDR_COUNT) begin
      hitCount = 1'b1;
    end else if (avsAddress == `GPTC_ADDR_CTRL) begin
      hitCtrl = 1'b1;
    end else if (avsAddress == `GPTC_ADDR_ACK) begin
      hitAck = 1'b1;
    end else if (avsAddress == `GPTC_ADDR_CAPTURE) begin
      hitCapture = 1'b1;
    end else if (avsAddress == `GPTC_ADDR_STATUS) begin
      hitStatus = 1'b1;
    end else if (avsAddress == `GPTC_ADDR_MASK) begin
      hitMask = 1'b1;
    end

    // Write strobes fire in the cycle in which waitrequest is low
    wrReload = wrEn & hitReload;
    wrCtrl = wrEn & hitCtrl;
    wrAck = wrEn & hitAck;
    wrStatus = wrEn & hitStatus;
    wrMask = wrEn & hitMask;

    // One wait state: read data is latched while waitrequest is high
    stateNext.ack = busReq & ~stateReg.ack;
    rdStrobe = avsRead & ~stateReg.ack;
    if (hitReload) begin
      rdMux = {16'h0000, stateReg.reloadVal};
    end else if (hitCount) begin
      rdMux = {16'h0000, stateReg.liveCount};
    end else if (hitCtrl) begin
      rdMux = stateReg.control & `GPTC_CTRL_WMASK;
    end else if (hitAck) begin
      rdMux = 32'h00000000;
    end else if (hitCapture) begin
      rdMux = {16'h0000, stateReg.captured};
    end else if (hitStatus) begin
      rdMux = {30'h00000000, stateReg.status};
    end else if (hitMask) begin
      rdMux = {30'h00000000, stateReg.mask};
    end
    if (rdStrobe) begin
      stateNext.readData = rdMux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator pin: two-stage synchroniser, then edge detect on the second stage
    stateNext.oscSync1 = osc32kIn;
    stateNext.oscSync2 = stateReg.oscSync1;
    stateNext.oscPrev = stateReg.oscSync2;
    oscTick = stateReg.oscSync2 & ~stateReg.oscPrev;

    ////////////////////////////////////////////////////////////////////////////
    // Core clock divided by two to the power of the core divider setting
    // Power-of-two masks keep the divider a plain compare
    case (coreDividerSetting)
      3'h0: cdMask = 7'h00;
      3'h1: cdMask = 7'h01;
      3'h2: cdMask = 7'h03;
      3'h3: cdMask = 7'h07;
      3'h4: cdMask = 7'h0f;
      3'h5: cdMask = 7'h1f;
      3'h6: cdMask = 7'h3f;
      default: cdMask = 7'h7f;
    endcase
    cdTick = coreTickIn & ((stateReg.cdCnt & cdMask) == cdMask);
    if (coreTickIn) begin
      stateNext.cdCnt = cdTick ? 7'h00 : 7'(stateReg.cdCnt + 7'h01);
    end

    clkSel = gptc_clksel_t'(stateReg.control[`GPTC_CLKSEL_HI:`GPTC_CLKSEL_LO]);
    // Reserved clock select gives no ticks
    case (clkSel)
      GPTC_CLK_OSC32K: srcTick = oscTick;
      GPTC_CLK_CORE_DIV: srcTick = cdTick;
      GPTC_CLK_CORE: srcTick = coreTickIn;
      GPTC_CLK_RESERVED: srcTick = 1'b0;
      default: srcTick = 1'b0;
    endcase

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler divides by two to the power of the scale code
    // Undefined scale codes still divide by a power of two
    case (stateReg.control[`GPTC_SCALE_HI:`GPTC_SCALE_LO])
      4'h0: preMask = 15'h0000;
      4'h1: preMask = 15'h0001;
      4'h2: preMask = 15'h0003;
      4'h3: preMask = 15'h0007;
      4'h4: preMask = 15'h000f;
      4'h5: preMask = 15'h001f;
      4'h6: preMask = 15'h003f;
      4'h7: preMask = 15'h007f;
      4'h8: preMask = 15'h00ff;
      4'h9: preMask = 15'h01ff;
      4'ha: preMask = 15'h03ff;
      4'hb: preMask = 15'h07ff;
      4'hc: preMask = 15'h0fff;
      4'hd: preMask = 15'h1fff;
      4'he: preMask = 15'h3fff;
      default: preMask = 15'h7fff;
    endcase
    preRun = stateReg.control[`GPTC_EN_BIT];
    preHit = (stateReg.preCnt & preMask) == preMask;
    preTick = preRun & srcTick & preHit;
    if (!preRun) begin
      stateNext.preCnt = 15'h0000;
    end else if (srcTick) begin
      stateNext.preCnt = preHit ? 15'h0000 : 15'(stateReg.preCnt + 15'h0001);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter
    countUp = stateReg.control[`GPTC_DIR_BIT];
    atMax = stateReg.liveCount == `GPTC_COUNT_MAX;
    atMin = stateReg.liveCount == `GPTC_COUNT_MIN;
    atTerminal = countUp ? atMax : atMin;
    cntStep = countUp ? 16'(stateReg.liveCount + 16'h0001)
                      : 16'(stateReg.liveCount - 16'h0001);
    cntWrap = countUp ? `GPTC_COUNT_MIN : `GPTC_COUNT_MAX;
    if (preTick) begin
      if (atTerminal) begin
        toEvent = 1'b1;
        if (stateReg.control[`GPTC_MOD_BIT]) begin
          stateNext.liveCount = stateReg.reloadVal;
        end else begin
          stateNext.liveCount = cntWrap;
        end
      end else begin
        stateNext.liveCount = cntStep;
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture on the rising edge of the selected source
    capSel = stateReg.control[`GPTC_CAPSEL_HI:`GPTC_CAPSEL_LO];
    // Selects past the last source never capture
    case (capSel)
      5'h00: srcLevel = irqSources[0];
      5'h01: srcLevel = irqSources[1];
      5'h02: srcLevel = irqSources[2];
      5'h03: srcLevel = irqSources[3];
      5'h04: srcLevel = irqSources[4];
      5'h05: srcLevel = irqSources[5];
      5'h06: srcLevel = irqSources[6];
      5'h07: srcLevel = irqSources[7];
      5'h08: srcLevel = irqSources[8];
      5'h09: srcLevel = irqSources[9];
      5'h0a: srcLevel = irqSources[10];
      5'h0b: srcLevel = irqSources[11];
      5'h0c: srcLevel = irqSources[12];
      5'h0d: srcLevel = irqSources[13];
      5'h0e: srcLevel = irqSources[14];
      5'h0f: srcLevel = irqSources[15];
      5'h10: srcLevel = irqSources[16];
      5'h11: srcLevel = irqSources[17];
      default: srcLevel = 1'b0;
    endcase

    stateNext.srcPrev = srcLevel;
    srcRise = srcLevel & ~stateReg.srcPrev;
    capArm = stateReg.control[`GPTC_CAPEN_BIT];
    if (capArm && srcRise) begin
      stateNext.captured = stateReg.liveCount;
      capEvent = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes, taken when waitrequest is low
    // Byte lanes merge into the old value before any register takes it
    reloadMerged = (stateReg.reloadVal & ~wMask[15:0]) | (avsWriteData[15:0] & wMask[15:0]);
    ctrlMerged = ((stateReg.control & ~wMask) | (avsWriteData & wMask)) & `GPTC_CTRL_WMASK;
    maskMerged = (stateReg.mask & ~wMask[1:0]) | (avsWriteData[1:0] & wMask[1:0]);
    if (wrReload) begin
      stateNext.reloadVal = reloadMerged;
      stateNext.liveCount = reloadMerged;
      stateNext.preCnt = 15'h0000;
    end
    if (wrCtrl) begin
      stateNext.control = ctrlMerged;
    end
    if (wrAck) begin
      stClr[`GPTC_ST_TIMEOUT] = 1'b1;
    end
    if (wrStatus) begin
      stClr = stClr | (avsWriteData[1:0] & wMask[1:0]);
    end
    if (wrMask) begin
      stateNext.mask = maskMerged;
    end

    // Events override clears so a coincident event is kept
    stSet[`GPTC_ST_TIMEOUT] = toEvent;
    stSet[`GPTC_ST_CAPTURE] = capEvent;
    stateNext.status = (stateReg.status & ~stClr) | stSet;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // Every field returns to a constant; the count reads all ones
      stateReg.status <= 2'h0;
      stateReg.mask <= 2'h0;
      stateReg.preCnt <= 15'h0000;
      stateReg.cdCnt <= 7'h00;
      stateReg.oscSync1 <= 1'b0;
      stateReg.oscSync2 <= 1'b0;
      stateReg.oscPrev <= 1'b0;
      stateReg.srcPrev <= 1'b0;
      stateReg.ack <= 1'b0;
      stateReg.readData <= 32'h00000000;
      stateReg.reloadVal <= `GPTC_RELOAD_RESET;
      stateReg.liveCount <= `GPTC_COUNT_RESET;
      stateReg.control <= `GPTC_CTRL_RESET;
      stateReg.captured <= `GPTC_CAPTURE_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Waitrequest is combinational so the first request cycle always stalls
  assign avsWaitRequest = (avsRead | avsWrite) & ~stateReg.ack;
  assign avsReadData = stateReg.readData;
  assign timerIrq = |(stateReg.status & stateReg.mask);

endmodule : gptc_timer

// >>> tb/gptc_timer_sva.sv
// Port-level assertions of the general-purpose timer
`timescale 1ns/1ns
`include "gptc_consts.svh"
module gptc_timer_chk
  import gptc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [31:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire logic osc32kIn,
  input wire logic coreTickIn,
  input wire logic [2:0] coreDividerSetting,
  input wire logic [17:0] irqSources,
  input wire logic timerIrq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence req_rise; $rose(avsRead || avsWrite); endsequence
  sequence rd_done; avsRead && !avsWaitRequest; endsequence
  wait_first_a: assert property (req_rise |-> avsWaitRequest) else $error("no wait");
  wait_end_a: assert property (req_rise |=> !avsWaitRequest) else $error("access too long");
  wait_idle_a: assert property (!(avsRead || avsWrite) |-> !avsWaitRequest) else $error("idle wait");
  ctrl_rsvd_a: assert property (rd_done ##0 avsAddress == `GPTC_ADDR_CTRL |->
    (avsReadData & ~`GPTC_CTRL_WMASK) == 32'h0) else $error("reserved bits set");
  half_word_a: assert property (rd_done ##0 (avsAddress == `GPTC_ADDR_COUNT ||
    avsAddress == `GPTC_ADDR_CAPTURE) |-> avsReadData[31:16] == 16'h0) else $error("upper bits");
  unmapped_zero_a: assert property (rd_done ##0 avsAddress[31:8] != 24'hffff03 |->
    avsReadData == 32'h0) else $error("unmapped read not zero");
  irq_hold_a: assert property (timerIrq && !(avsWrite && !avsWaitRequest) |=> timerIrq)
    else $error("irq dropped");
  irq_reset_a: assert property ($fell(reset) |-> !timerIrq) else $error("irq after reset");
endmodule : gptc_timer_chk
bind gptc_timer gptc_timer_chk gptc_timer_chk_inst (.sys_clk(sys_clk), .reset(reset),
  .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .osc32kIn(osc32kIn), .coreTickIn(coreTickIn), .coreDividerSetting(coreDividerSetting),
  .irqSources(irqSources), .timerIrq(timerIrq));

// >>> tb/tb_top.sv
// Self-checking bench of the general-purpose timer
`timescale 1ns/1ns
`include "gptc_consts.svh"
`define CHK(a, e) begin nCompared++; if ((a) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  logic sys_clk = 0, reset = 1, avsRead = 0, avsWrite = 0, coreTickIn = 0, osc32kIn = 0;
  logic [2:0] coreDividerSetting = 0;
  logic [31:0] avsAddress = 0, avsWriteData = 0, avsReadData, q;
  logic [17:0] irqSources = 0;
  logic avsWaitRequest, timerIrq;
  int errors = 0, nCompared = 0;
  logic [31:0] rows [5][2] = '{'{`GPTC_ADDR_RELOAD, 0}, '{`GPTC_ADDR_COUNT, 32'hffff},
    '{`GPTC_ADDR_CTRL, 0}, '{`GPTC_ADDR_CAPTURE, 0}, '{32'hffff0400, 0}};
  gptc_timer gptc_timer_inst (.sys_clk(sys_clk), .reset(reset), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hf), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .osc32kIn(osc32kIn), .coreTickIn(coreTickIn), .coreDividerSetting(coreDividerSetting),
    .irqSources(irqSources), .timerIrq(timerIrq));
  initial forever #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("compared %0d mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task bus(input logic w, input logic [31:0] a, d);
    int i;
    @(posedge sys_clk);
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWriteData <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (avsWaitRequest !== 1'b0 && i < 9);
    q = avsReadData;
    avsRead <= 0;
    avsWrite <= 0;
    if (i >= 9) begin
      errors++;
      close_out();
    end
  endtask : bus
  task rd(input logic [31:0] a, e);
    bus(0, a, 0);
    `CHK(q, e)
  endtask : rd
  task tick(input int n);
    repeat (n) begin
      coreTickIn <= 1;
      @(posedge sys_clk);
      coreTickIn <= 0;
      @(posedge sys_clk);
    end
  endtask : tick
  task rst_rows;
    reset <= 1;
    repeat (4) @(posedge sys_clk);
    reset <= 0;
    for (int i = 0; i < 5; i++) rd(rows[i][0], rows[i][1]);
    $display("test reset done");
  endtask : rst_rows
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    close_out();
  end
  initial begin
    rst_rows();
    bus(1, `GPTC_ADDR_CTRL, 32'hffffffff);
    rd(`GPTC_ADDR_CTRL, `GPTC_CTRL_WMASK);
    bus(1, `GPTC_ADDR_MASK, 32'h3);
    bus(1, `GPTC_ADDR_RELOAD, 32'h1234);
    bus(1, `GPTC_ADDR_CTRL, 32'h00023000);
    irqSources[2] <= 1;
    repeat (4) @(posedge sys_clk);
    rd(`GPTC_ADDR_CAPTURE, 32'h0);
    irqSources[3] <= 1;
    repeat (4) @(posedge sys_clk);
    rd(`GPTC_ADDR_CAPTURE, 32'h1234);
    `CHK(timerIrq, 1'b1)
    bus(1, `GPTC_ADDR_STATUS, 32'h2);
    repeat (4) @(posedge sys_clk);
    `CHK(timerIrq, 1'b0)
    bus(1, `GPTC_ADDR_CTRL, 32'h00003000);
    bus(1, `GPTC_ADDR_RELOAD, 32'h0042);
    irqSources[3] <= 0;
    repeat (4) @(posedge sys_clk);
    irqSources[3] <= 1;
    repeat (4) @(posedge sys_clk);
    rd(`GPTC_ADDR_CAPTURE, 32'h1234);
    bus(1, `GPTC_ADDR_COUNT, 32'h0);
    rd(`GPTC_ADDR_COUNT, 32'h0042);
    $display("test capture done");
    bus(1, `GPTC_ADDR_RELOAD, 32'h3);
    bus(1, `GPTC_ADDR_CTRL, 32'h000004c0);
    tick(2);
    rd(`GPTC_ADDR_COUNT, 32'h1);
    `CHK(timerIrq, 1'b0)
    tick(2);
    `CHK(timerIrq, 1'b1)
    bus(1, `GPTC_ADDR_ACK, 32'h0);
    @(posedge sys_clk);
    `CHK(timerIrq, 1'b0)
    bus(1, `GPTC_ADDR_RELOAD, 32'h0);
    bus(1, `GPTC_ADDR_CTRL, 32'h00000584);
    tick(40);
    rd(`GPTC_ADDR_COUNT, 32'h2);
    bus(1, `GPTC_ADDR_CTRL, 32'h00000504);
    tick(20);
    rd(`GPTC_ADDR_COUNT, 32'h2);
    $display("test count done");
    bus(1, `GPTC_ADDR_RELOAD, 32'h0);
    coreDividerSetting <= 3'h1;
    bus(1, `GPTC_ADDR_CTRL, 32'h00000380);
    tick(8);
    rd(`GPTC_ADDR_COUNT, 32'h4);
    bus(1, `GPTC_ADDR_RELOAD, 32'h0);
    bus(1, `GPTC_ADDR_CTRL, 32'h00000180);
    repeat (3) begin
      osc32kIn <= 1;
      repeat (3) @(posedge sys_clk);
      osc32kIn <= 0;
      repeat (3) @(posedge sys_clk);
    end
    rd(`GPTC_ADDR_COUNT, 32'h3);
    $display("test clock done");
    rst_rows();
    close_out();
  end
endmodule : tb_top
